// ---- occ_consts.svh ----
/*
  Offsets, field positions, reset values and frame constants for the output
  channel source control block. Assumes inclusion by bare name.
*/
`ifndef OCC_CONSTS_SVH
`define OCC_CONSTS_SVH

`define OCC_NUM_CH 10
`define OCC_REG_W 12
`define OCC_FRAME_BITS 16
`define OCC_CMD_HI 15
`define OCC_CMD_LO 12
`define OCC_CMD_ON_OFF 4'h8
`define OCC_CMD_BANK_A 4'h9
`define OCC_CMD_BANK_B 4'hA
`define OCC_CMD_PAIRING 4'hB
`define OCC_CMD_DIAG 4'hC
`define OCC_ON_OFF_RST 12'hC00
`define OCC_ON_OFF_FIXED 12'hC00
`define OCC_BANK_A_RST 12'hAAA
`define OCC_BANK_B_RST 12'h0AA
`define OCC_BANK_B_MASK 12'h0FF
`define OCC_PAIRING_RST 12'h000
`define OCC_PAIRING_MASK 12'h0F7
`define OCC_BANK_A_CH 6

`endif

// ---- occ_pkg.sv ----
/*
  Types shared by the output channel source control block.
  Assumes occ_consts.svh is compiled alongside.
*/
package occ_pkg;
  typedef struct packed {
    logic [3:0] cmd;
    logic [11:0] data;
  } occ_frame_type;

  typedef struct packed {
    logic [11:0] on_off;
    logic [11:0] bank_a;
    logic [11:0] bank_b;
    logic [11:0] pairing;
    logic [9:0] diag;
  } occ_regs_type;

  typedef enum logic [0:0] {
    OCC_IDLE,
    OCC_SHIFT
  } occ_state_type;
endpackage

// ---- occ_channel_ctrl.sv ----
/*
  Serial register bank and source selection for ten low-side channels.
  Assumes serial-port pins and input pins are synchronous to core_clk.
*/
`timescale 1ns/1ps
`include "occ_consts.svh"

module occ_channel_ctrl #(
  parameter int NUM_CH = `OCC_NUM_CH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Serial port
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_si,
  output logic spi_so,
  // Channel side
  input wire logic [9:0] channel_input_pin,
  input wire logic [9:0] channel_fault,
  output logic [9:0] output_channel,
  output logic [9:0] diag_bits
);

  // The selector and pairing layouts are fixed for ten channels, so refuse any other count.
  if (NUM_CH != `OCC_NUM_CH) begin : g_bad_num_ch
    $error("occ_channel_ctrl serves exactly ten channels");
  end

  occ_pkg::occ_regs_type regs_r, regs_nxt;
  occ_pkg::occ_state_type state_r, state_nxt;
  logic [15:0] shift_r, shift_nxt;
  logic [15:0] resp_r, resp_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [3:0] last_cmd_r, last_cmd_nxt;
  logic sclk_q_r, cs_q_r;
  logic so_r, so_nxt;
  logic [9:0] out_r, out_nxt;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise, commit;
  occ_pkg::occ_frame_type frame;

  assign sclk_rise = spi_sclk & ~sclk_q_r;
  assign sclk_fall = ~spi_sclk & sclk_q_r;
  assign cs_fall = ~spi_cs_n & cs_q_r;
  assign cs_rise = spi_cs_n & ~cs_q_r;
  assign frame = shift_r;
  // A frame counts only with exactly sixteen clocks; anything else is dropped.
  assign commit = (state_r == occ_pkg::OCC_SHIFT) && cs_rise
                  && (cnt_r == 5'(`OCC_FRAME_BITS));

  // Two-bit selector of channel index ch, split across both banks.
  function automatic logic [1:0] sel_of(input occ_pkg::occ_regs_type r, input int ch);
    logic [1:0] s;
    s = 2'b00;
    if (ch < `OCC_BANK_A_CH) begin
      s = r.bank_a[2*ch +: 2];
    end else begin
      s = r.bank_b[2*(ch-`OCC_BANK_A_CH) +: 2];
    end
    return s;
  endfunction

  // Pairing bit that ties channel index ch to the channel just below it. The edges between
  // the groups have no bit, so channels four and six never follow a neighbour.
  function automatic logic pair_of(input occ_pkg::occ_regs_type r, input int ch);
    logic p;
    p = 1'b0;
    case (ch)
      1, 2, 3: p = r.pairing[ch-1];
      5: p = r.pairing[4];
      7, 8, 9: p = r.pairing[ch-2];
      default: p = 1'b0;
    endcase
    return p;
  endfunction

  // Readback of the register that a command names.
  function automatic logic [11:0] read_of(input occ_pkg::occ_regs_type r, input logic [3:0] c);
    logic [11:0] v;
    v = 12'h000;
    case (c)
      `OCC_CMD_ON_OFF: v = r.on_off;
      `OCC_CMD_BANK_A: v = r.bank_a;
      `OCC_CMD_BANK_B: v = r.bank_b;
      `OCC_CMD_PAIRING: v = r.pairing;
      `OCC_CMD_DIAG: v = {2'b00, r.diag};
      default: v = 12'h000;
    endcase
    return v;
  endfunction

  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    resp_nxt = resp_r;
    cnt_nxt = cnt_r;
    so_nxt = so_r;
    last_cmd_nxt = last_cmd_r;
    regs_nxt = regs_r;
    case (state_r)
      occ_pkg::OCC_IDLE: begin
        if (cs_fall) begin
          state_nxt = occ_pkg::OCC_SHIFT;
          cnt_nxt = 5'd0;
          resp_nxt = {last_cmd_r, read_of(regs_r, last_cmd_r)};
          so_nxt = last_cmd_r[3];
        end
      end
      occ_pkg::OCC_SHIFT: begin
        if (cs_rise) begin
          state_nxt = occ_pkg::OCC_IDLE;
          so_nxt = 1'b0;
        end else begin
          if (sclk_rise) begin
            shift_nxt = {shift_r[14:0], spi_si};
            if (cnt_r != 5'(`OCC_FRAME_BITS + 1)) begin
              cnt_nxt = cnt_r + 5'd1;
            end
          end
          if (sclk_fall) begin
            resp_nxt = {resp_r[14:0], 1'b0};
            so_nxt = resp_r[14];
          end
        end
      end
      default: state_nxt = occ_pkg::OCC_IDLE;
    endcase
    if (commit) begin
      last_cmd_nxt = frame.cmd;
      case (frame.cmd)
        `OCC_CMD_ON_OFF: regs_nxt.on_off = frame.data | `OCC_ON_OFF_FIXED;
        `OCC_CMD_BANK_A: regs_nxt.bank_a = frame.data;
        `OCC_CMD_BANK_B: regs_nxt.bank_b = frame.data & `OCC_BANK_B_MASK;
        `OCC_CMD_PAIRING: regs_nxt.pairing = frame.data & `OCC_PAIRING_MASK;
        default: regs_nxt = regs_nxt;
      endcase
    end
    // Reading diagnosis clears it, but a fault in the same cycle stays set.
    if (commit && frame.cmd == `OCC_CMD_DIAG) begin
      regs_nxt.diag = 10'h000;
    end
    regs_nxt.diag = regs_nxt.diag | channel_fault;
  end

  // Paired channels chain upward, so a paired group of four follows its lowest member.
  always_comb begin
    logic [9:0] ctl;
    logic [1:0] s;
    ctl = 10'h000;
    s = 2'b00;
    for (int i = 0; i < `OCC_NUM_CH; i++) begin
      s = sel_of(regs_r, i);
      case (s)
        2'b10: ctl[i] = channel_input_pin[i];
        2'b11: ctl[i] = regs_r.on_off[i] & channel_input_pin[i];
        default: ctl[i] = regs_r.on_off[i];
      endcase
      if (i > 0) begin
        if (pair_of(regs_r, i)) begin
          ctl[i] = ctl[i-1];
        end
      end
    end
    out_nxt = ctl;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      regs_r.on_off <= `OCC_ON_OFF_RST;
      regs_r.bank_a <= `OCC_BANK_A_RST;
      regs_r.bank_b <= `OCC_BANK_B_RST;
      regs_r.pairing <= `OCC_PAIRING_RST;
      regs_r.diag <= 10'h000;
      state_r <= occ_pkg::OCC_IDLE;
      shift_r <= 16'h0000;
      resp_r <= 16'h0000;
      cnt_r <= 5'd0;
      last_cmd_r <= 4'h0;
      so_r <= 1'b0;
      out_r <= 10'h000;
      sclk_q_r <= 1'b0;
      cs_q_r <= 1'b1;
    end else begin
      regs_r <= regs_nxt;
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      resp_r <= resp_nxt;
      cnt_r <= cnt_nxt;
      last_cmd_r <= last_cmd_nxt;
      so_r <= so_nxt;
      out_r <= out_nxt;
      sclk_q_r <= spi_sclk;
      cs_q_r <= spi_cs_n;
    end
  end

  assign spi_so = so_r;
  assign output_channel = out_r;
  assign diag_bits = regs_r.diag;

  logic [1:0] sel0;
  assign sel0 = regs_r.bank_a[1:0];

  sequence s_full_frame;
    (state_r == occ_pkg::OCC_SHIFT) && cs_rise && (cnt_r == 5'd16);
  endsequence

  a_upper_ones: assert property (@(posedge core_clk) disable iff (rst)
    regs_r.on_off[11:10] == 2'b11) else $error("on/off upper bits not ones");
  a_serial_mode: assert property (@(posedge core_clk) disable iff (rst)
    (sel0[1] == 1'b0) |=> output_channel[0] == $past(regs_r.on_off[0]))
    else $error("serial mode channel mismatch");
  a_input_mode: assert property (@(posedge core_clk) disable iff (rst)
    (sel0 == 2'b10) |=> output_channel[0] == $past(channel_input_pin[0]))
    else $error("input mode channel mismatch");
  a_and_mode: assert property (@(posedge core_clk) disable iff (rst)
    (sel0 == 2'b11) |=> output_channel[0] == ($past(regs_r.on_off[0])
    & $past(channel_input_pin[0]))) else $error("and mode channel mismatch");
  a_pair_follow: assert property (@(posedge core_clk) disable iff (rst)
    regs_r.pairing[0] |=> output_channel[1] == output_channel[0])
    else $error("paired channel not matched");
  a_pair_upper_group: assert property (@(posedge core_clk) disable iff (rst)
    regs_r.pairing[5] |=> output_channel[7] == output_channel[6])
    else $error("upper group pair not matched");
  a_pair_reserved: assert property (@(posedge core_clk) disable iff (rst)
    regs_r.pairing[11:8] == 4'h0 && regs_r.pairing[3] == 1'b0)
    else $error("pairing reserved bit set");
  a_bank_b_upper: assert property (@(posedge core_clk) disable iff (rst)
    regs_r.bank_b[11:8] == 4'h0) else $error("bank B upper bits set");
  a_no_partial: assert property (@(posedge core_clk) disable iff (rst)
    !commit |=> $stable(regs_r.on_off) && $stable(regs_r.bank_a)
    && $stable(regs_r.pairing)) else $error("register changed without frame");
  a_frame_write: assert property (@(posedge core_clk) disable iff (rst)
    s_full_frame ##0 (frame.cmd == 4'h8) |=> regs_r.on_off[9:0] == $past(frame.data[9:0]))
    else $error("on/off write lost");
  a_diag_sticky: assert property (@(posedge core_clk) disable iff (rst)
    channel_fault[1] |=> diag_bits[1]) else $error("diagnosis bit not set");
  a_reset_sel: assert property (@(posedge core_clk) disable iff (rst)
    $past(rst) |-> regs_r.bank_a == 12'hAAA && regs_r.bank_b == 12'h0AA
    && output_channel == 10'h000) else $error("reset values wrong");

endmodule

// ---- occ_host_model.sv ----
/*
  Behavioural host that shifts 16-bit command frames into the serial port.
  Assumes the device samples its serial pins on rising edges of core_clk.
*/
`timescale 1ns/1ps
module occ_host_model (
  // Clock
  input wire logic core_clk,
  // Serial port
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_si,
  input wire logic spi_so
);
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_si = 1'b0;
  end
  // A clock count other than 16 is only used to provoke a refused frame.
  task automatic xfer(input logic [15:0] tx, input int nclk, output logic [15:0] rx);
    int i;
    rx = 16'h0000;
    @(posedge core_clk);
    spi_cs_n <= 1'b0;
    for (i = 0; i < nclk; i++) begin
      spi_si <= tx[15 - (i % 16)];
      repeat (3) @(posedge core_clk);
      rx = {rx[14:0], spi_so};
      spi_sclk <= 1'b1;
      repeat (2) @(posedge core_clk);
      spi_sclk <= 1'b0;
    end
    repeat (2) @(posedge core_clk);
    spi_cs_n <= 1'b1;
    // Outside a frame the data line must not keep looking valid.
    spi_si <= ~spi_si;
    repeat (4) @(posedge core_clk);
  endtask
endmodule

// ---- tb_top.sv ----
/*
  Self-checking bench for the output channel source control block.
  Assumes occ_consts.svh and occ_host_model.sv are compiled alongside.
*/
`timescale 1ns/1ps
`include "occ_consts.svh"
module tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic spi_cs_n, spi_sclk, spi_si, spi_so;
  logic [9:0] pins = 10'h000, faults = 10'h000, outs, diag;
  logic [15:0] rx;
  int fail_count = 0, compares = 0, cyc = 0;
  always #2.5 core_clk = ~core_clk;
  occ_channel_ctrl occ_channel_ctrl_i (.core_clk(core_clk), .rst(rst), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .spi_si(spi_si), .spi_so(spi_so), .channel_input_pin(pins),
    .channel_fault(faults), .output_channel(outs), .diag_bits(diag));
  occ_host_model occ_host_model_i (.core_clk(core_clk), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .spi_si(spi_si), .spi_so(spi_so));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] cmd, input logic [11:0] data);
    occ_host_model_i.xfer({cmd, data}, 16, rx);
  endtask
  // The answer comes one frame late, so a diagnosis frame, which clears only the diagnosis bits, fetches it.
  task automatic rd(input logic [3:0] cmd, input logic [11:0] exp);
    occ_host_model_i.xfer({`OCC_CMD_DIAG, 12'h000}, 16, rx);
    chk("readback", {cmd, exp}, rx);
  endtask
  task automatic pin_out(input logic [9:0] p, input logic [9:0] exp);
    pins <= p;
    repeat (3) @(posedge core_clk);
    chk("output_channel", {6'h00, exp}, {6'h00, outs});
  endtask
  task automatic t_reset;
    pin_out(10'h2A5, 10'h2A5);
    wr(`OCC_CMD_BANK_A, 12'h000);
    pin_out(10'h3FF, 10'h3C0);
    rd(`OCC_CMD_BANK_A, 12'h000);
    $display("t_reset done");
  endtask
  task automatic t_serial;
    wr(`OCC_CMD_BANK_B, 12'h000);
    wr(`OCC_CMD_ON_OFF, 12'h155);
    rd(`OCC_CMD_ON_OFF, 12'hD55);
    pin_out(10'h2AA, 10'h155);
    wr(`OCC_CMD_BANK_A, 12'h555);
    wr(`OCC_CMD_BANK_B, 12'hF55);
    rd(`OCC_CMD_BANK_B, 12'h055);
    pin_out(10'h3FF, 10'h155);
    $display("t_serial done");
  endtask
  task automatic t_and;
    wr(`OCC_CMD_BANK_A, 12'hFFF);
    wr(`OCC_CMD_BANK_B, 12'h0FF);
    pin_out(10'h0F3, 10'h051);
    pin_out(10'h000, 10'h000);
    $display("t_and done");
  endtask
  task automatic t_partial;
    int n;
    wr(`OCC_CMD_BANK_A, 12'h000);
    wr(`OCC_CMD_BANK_B, 12'h000);
    wr(`OCC_CMD_ON_OFF, 12'h0F0);
    for (n = 15; n <= 17; n += 2) begin
      occ_host_model_i.xfer({`OCC_CMD_ON_OFF, 12'h30F}, n, rx);
      pin_out(10'h3FF, 10'h0F0);
    end
    $display("t_partial done");
  endtask
  task automatic t_pairing;
    wr(`OCC_CMD_BANK_A, 12'hAAA);
    wr(`OCC_CMD_BANK_B, 12'h0AA);
    wr(`OCC_CMD_PAIRING, 12'hFFF);
    rd(`OCC_CMD_PAIRING, 12'h0F7);
    pin_out(10'h001, 10'h00F);
    pin_out(10'h010, 10'h030);
    pin_out(10'h040, 10'h3C0);
    wr(`OCC_CMD_PAIRING, 12'h001);
    pin_out(10'h002, 10'h000);
    pin_out(10'h001, 10'h003);
    $display("t_pairing done");
  endtask
  task automatic t_diag;
    faults <= 10'h002;
    @(posedge core_clk);
    faults <= 10'h000;
    repeat (2) @(posedge core_clk);
    chk("diag_bits", 16'h0002, {6'h00, diag});
    chk("paired fault", 16'h0001, {15'h0000, diag[0] | diag[1]});
    wr(`OCC_CMD_DIAG, 12'h000);
    chk("diag_bits", 16'h0000, {6'h00, diag});
    $display("t_diag done");
  endtask
  task automatic results;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    t_reset();
    t_serial();
    t_and();
    t_partial();
    t_pairing();
    t_diag();
    results();
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
endmodule
